// >>> rtl/pump_speed_ctl.sv
// Run status and speed mode controller for a vacuum pump drive, with APB registers.
// Assumes contact and panel inputs are asynchronous pins; APB runs on pclk.
`timescale 1ns/1ps

module pump_speed_ctl
    import pump_ctl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic start_in,
    input wire logic stop_in,
    input wire logic low_in,
    input wire logic panel_toggle_in,
    input wire logic panel_startstop_in,
    input wire logic fault_in,
    input wire logic [15:0] motor_current_in,
    output logic at_speed_out,
    output logic motor_drive_out
);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [5:0] sync1_q;
    logic [5:0] sync2_q;
    logic [5:0] prev_q;
    logic [15:0] cur1_q;
    logic [15:0] cur2_q;
    logic start_s, stop_s, low_s, panel_tog_s, panel_ss_s, fault_s;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q <= '0;
            cur1_q <= '0;
            cur2_q <= '0;
        end else begin
            sync1_q <= {fault_in, panel_startstop_in, panel_toggle_in, low_in, stop_in, start_in};
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
            cur1_q <= motor_current_in;
            cur2_q <= cur1_q;
        end
    end

    assign {fault_s, panel_ss_s, panel_tog_s, low_s, stop_s, start_s} = sync2_q;

    logic start_rise, stop_rise, tog_rise, ss_rise, fault_rise;
    assign start_rise = start_s && !prev_q[0];
    assign stop_rise = stop_s && !prev_q[1];
    assign tog_rise = panel_tog_s && !prev_q[3];
    assign ss_rise = panel_ss_s && !prev_q[4];
    assign fault_rise = fault_s && !prev_q[5];

    // Current reading is a multi-bit word: take it only once two samples agree
    logic [15:0] cur3_q;
    logic [15:0] cur_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur3_q <= '0;
            cur_q <= '0;
        end else begin
            cur3_q <= cur2_q;
            if (cur3_q == cur2_q) begin
                cur_q <= cur3_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave
    logic acc;
    logic wr;
    logic rd;
    cmd_t cmd;
    logic online_cmd, offline_cmd, panel_cmd;
    logic bad_addr;

    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign bad_addr = !(paddr inside {CTRL_OFS, CMD_OFS, SETPT_OFS, STATUS_OFS, SPEED_OFS, CURRENT_OFS});

    logic cmd_wr;
    assign cmd_wr = wr && paddr == CMD_OFS;
    assign cmd.start = cmd_wr && pwdata[CMD_START_BIT];
    assign cmd.stop = cmd_wr && pwdata[CMD_STOP_BIT];
    assign cmd.low = cmd_wr && pwdata[CMD_LOW_BIT];
    assign cmd.full = cmd_wr && pwdata[CMD_FULL_BIT];
    assign cmd.arst = cmd_wr && pwdata[CMD_ARST_BIT];
    assign online_cmd = cmd_wr && pwdata[CMD_ONLINE_BIT];
    assign offline_cmd = cmd_wr && pwdata[CMD_OFFLINE_BIT];
    assign panel_cmd = cmd_wr && pwdata[CMD_PANEL_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Control mode
    ctl_mode_t mode_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= MODE_CONTACT;
        end else if (online_cmd) begin
            mode_q <= MODE_SERIAL;
        end else if (offline_cmd && mode_q == MODE_SERIAL) begin
            mode_q <= MODE_CONTACT;
        end else if ((tog_rise || panel_cmd) && mode_q != MODE_SERIAL) begin
            mode_q <= (mode_q == MODE_PANEL) ? MODE_CONTACT : MODE_PANEL;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Setpoint, written only over the serial bus
    logic [9:0] setpt_q;
    logic [9:0] setpt_req;

    assign setpt_req = pwdata[9:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setpt_q <= SETPT_RST;
        end else if (wr && paddr == SETPT_OFS) begin
            if (setpt_req < SPEED_MIN_SET) begin
                setpt_q <= SPEED_MIN_SET;
            end else if (setpt_req > SPEED_FULL) begin
                setpt_q <= SPEED_FULL;
            end else begin
                setpt_q <= setpt_req;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Run request, rate selection and alarm
    logic run_q;
    logic low_ser_q;
    logic alarm_q;
    logic low_sel;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= 1'b0;
        end else if (alarm_q || fault_s) begin
            run_q <= 1'b0;
        end else begin
            case (mode_q)
                MODE_SERIAL: begin
                    if (cmd.stop) begin
                        run_q <= 1'b0;
                    end else if (cmd.start) begin
                        run_q <= 1'b1;
                    end
                end
                MODE_CONTACT: begin
                    if (stop_rise) begin
                        run_q <= 1'b0;
                    end else if (start_rise) begin
                        run_q <= 1'b1;
                    end
                end
                MODE_PANEL: begin
                    if (ss_rise) begin
                        run_q <= !run_q;
                    end
                end
                default: run_q <= 1'b0;
            endcase
        end
    end

    // Serial rate selection, accepted at any time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_ser_q <= 1'b0;
        end else if (cmd.low) begin
            low_ser_q <= 1'b1;
        end else if (cmd.full) begin
            low_ser_q <= 1'b0;
        end
    end

    // Alarm: fault set wins over reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_q <= 1'b0;
        end else if (fault_rise || fault_s) begin
            alarm_q <= 1'b1;
        end else if (cmd.arst) begin
            alarm_q <= 1'b0;
        end
    end

    always_comb begin
        case (mode_q)
            MODE_CONTACT: low_sel = low_s;
            MODE_SERIAL: low_sel = low_ser_q;
            default: low_sel = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Rotor speed model
    logic [9:0] speed_q;
    logic [9:0] target;
    logic [$clog2(RAMP_CYCLES + 1) - 1:0] ramp_q;
    logic tick;

    assign target = !run_q ? 10'h000 : (low_sel ? setpt_q : SPEED_FULL);
    assign tick = ramp_q == '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ramp_q <= '0;
        end else if (tick) begin
            ramp_q <= ($clog2(RAMP_CYCLES + 1))'(RAMP_CYCLES - 1);
        end else begin
            ramp_q <= ramp_q - 1'b1;
        end
    end

    // Same rate for every change; hold on reaching the target
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            speed_q <= '0;
        end else if (tick) begin
            if (speed_q < target) begin
                speed_q <= speed_q + 10'h001;
            end else if (speed_q > target) begin
                speed_q <= speed_q - 10'h001;
            end
        end // Holds otherwise
    end

    ////////////////////////////////////////////////////////////////////////
    // At-speed threshold and run status
    logic [9:0] low80;
    logic [9:0] thresh;
    logic at_d;
    run_state_t state_q;
    run_state_t state_d;

    assign low80 = 10'((14'(setpt_q) * 14'h0004) / 14'h0005);
    // Contact reduced start uses 80% of setpoint; serial uses 80% rated
    assign thresh = (mode_q == MODE_CONTACT && low_sel) ? low80 : SPEED_AT_80;

    always_comb begin
        at_d = 1'b0;
        if (run_q && !alarm_q) begin
            if (low_sel && speed_q > setpt_q) begin
                at_d = (mode_q == MODE_SERIAL) ? (speed_q == target) : 1'b0;
            end else if (low_sel && speed_q == setpt_q) begin
                at_d = 1'b1;
            end else begin
                at_d = speed_q >= thresh;
            end
        end
    end

    always_comb begin
        if (alarm_q) begin
            state_d = (speed_q == '0) ? RUN_ESTOP : RUN_EIDLE;
        end else if (!run_q) begin
            state_d = (speed_q == '0) ? RUN_STOP : RUN_IDLE;
        end else if (at_d) begin
            state_d = RUN_NORMAL;
        end else if (speed_q > target) begin
            state_d = RUN_IDLE;
        end else begin
            state_d = RUN_ACCEL;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= RUN_STOP;
            at_speed_out <= 1'b0;
            motor_drive_out <= 1'b0;
        end else begin
            state_q <= state_d;
            at_speed_out <= at_d;
            motor_drive_out <= run_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB read and response
    logic [31:0] rdata_d;

    always_comb begin
        rdata_d = 32'h0000_0000;
        case (paddr)
            CTRL_OFS: rdata_d = {28'h0000000, low_ser_q, 1'b0, mode_q};
            SETPT_OFS: rdata_d = {22'h000000, setpt_q};
            STATUS_OFS: rdata_d = {27'h0000000, alarm_q, run_q, state_q};
            SPEED_OFS: rdata_d = {22'h000000, speed_q};
            CURRENT_OFS: rdata_d = {16'h0000, cur_q};
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= (psel && !penable && !pwrite) ? rdata_d : prdata;
            pready <= psel && !penable;
            pslverr <= psel && !penable && bad_addr;
        end
    end

endmodule

// >>> rtl/pump_ctl_pkg.sv
// Shared constants and types for the pump speed mode and run status controller.
// Assumes a 32-bit APB master on pclk.
package pump_ctl_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CMD_OFS = 8'h04;
    localparam logic [7:0] SETPT_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0C;
    localparam logic [7:0] SPEED_OFS = 8'h10;
    localparam logic [7:0] CURRENT_OFS = 8'h14;

    // Command register bit positions (write one to issue)
    localparam int CMD_START_BIT = 0;
    localparam int CMD_STOP_BIT = 1;
    localparam int CMD_LOW_BIT = 2;
    localparam int CMD_FULL_BIT = 3;
    localparam int CMD_ARST_BIT = 4;
    localparam int CMD_ONLINE_BIT = 5;
    localparam int CMD_OFFLINE_BIT = 6;
    localparam int CMD_PANEL_BIT = 7;

    // Speed in tenths of a percent of rated speed
    localparam logic [9:0] SPEED_FULL = 10'h3E8;
    localparam logic [9:0] SPEED_MIN_SET = 10'h0FA;
    localparam logic [9:0] SPEED_AT_80 = 10'h320;
    localparam logic [9:0] SETPT_RST = 10'h3E8;

    // Rotor rate model: one tenth of a percent every RAMP time
    localparam int RAMP_NS = 1000;
    localparam int CLK_NS = 20;
    localparam int RAMP_CYCLES = (RAMP_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [1:0] {
        MODE_PANEL,
        MODE_CONTACT,
        MODE_SERIAL
    } ctl_mode_t;

    typedef enum logic [2:0] {
        RUN_NORMAL,
        RUN_ACCEL,
        RUN_IDLE,
        RUN_STOP,
        RUN_ESTOP,
        RUN_EIDLE
    } run_state_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic low;
        logic full;
        logic arst;
    } cmd_t;

endpackage

// >>> bench/pump_speed_ctl_props.sv
// Checker for the pump controller register port and drive output.
// Assumes it is bound to pump_speed_ctl and sees only its ports.
`timescale 1ns/1ps
module pump_speed_ctl_props
    import pump_ctl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic fault_in,
    input wire logic motor_drive_out
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire setup = psel && !penable;
    property p_ready_next; setup |=> pready; endproperty
    a_ready_next: assert property (p_ready_next) else $error("pready missing after setup");
    property p_ready_once; pready |=> !pready; endproperty
    a_ready_once: assert property (p_ready_once) else $error("pready longer than one cycle");
    property p_no_ready; !setup |=> !pready; endproperty
    a_no_ready: assert property (p_no_ready) else $error("pready without setup");
    property p_err_ready; pslverr |-> pready; endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
    wire mapped = paddr inside {CTRL_OFS, CMD_OFS, SETPT_OFS, STATUS_OFS, SPEED_OFS, CURRENT_OFS};
    property p_unmapped; setup && !mapped |=> pslverr; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_mapped; setup && mapped |=> !pslverr; endproperty
    a_mapped: assert property (p_mapped) else $error("mapped access refused");
    property p_rdata_hold; !setup |=> $stable(prdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved outside setup");
    property p_fault_off; fault_in [*6] |-> !motor_drive_out; endproperty
    a_fault_off: assert property (p_fault_off) else $error("drive kept on during alarm");
    cover property (setup && paddr > 8'h14);
    cover property ($rose(motor_drive_out));
    cover property (fault_in [*6]);
endmodule
bind pump_speed_ctl pump_speed_ctl_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fault_in(fault_in), .motor_drive_out(motor_drive_out));

// >>> bench/pump_host_model.sv
// Host equipment model driving the contact, panel and fault pins.
// Assumes pins are held long enough to pass a two-flop synchroniser.
`timescale 1ns/1ps
module pump_host_model (
    input wire logic pclk,
    output logic start_in,
    output logic stop_in,
    output logic low_in,
    output logic panel_toggle_in,
    output logic panel_startstop_in,
    output logic fault_in,
    output logic [15:0] motor_current_in
);
    logic [5:0] pins_q = 6'h00;
    assign {fault_in, panel_startstop_in, panel_toggle_in, low_in, stop_in, start_in} = pins_q;
    assign motor_current_in = 16'h1234;
    task automatic set(input int k, input logic v);
        @(posedge pclk);
        pins_q[k] <= v;
    endtask
    // Contact pulse held four cycles so the edge detector sees it
    task automatic press(input int k);
        set(k, 1'b1);
        repeat (4) @(posedge pclk);
        pins_q[k] <= 1'b0;
    endtask
endmodule

// >>> bench/testbench.sv
// Self-checking bench for the pump controller over APB and contacts.
// Assumes the host model drives the pins and the checker is bound.
`timescale 1ns/1ps
module testbench;
    import pump_ctl_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, at_speed_out, motor_drive_out, err;
    logic start_in, stop_in, low_in, panel_toggle_in, panel_startstop_in, fault_in;
    logic [15:0] motor_current_in;
    int failures = 0;
    int total_checks = 0;
    int n;
    pump_speed_ctl u_pump_speed_ctl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .start_in(start_in), .stop_in(stop_in), .low_in(low_in),
        .panel_toggle_in(panel_toggle_in), .panel_startstop_in(panel_startstop_in), .fault_in(fault_in),
        .motor_current_in(motor_current_in), .at_speed_out(at_speed_out), .motor_drive_out(motor_drive_out));
    pump_host_model u_pump_host_model (.pclk(pclk), .start_in(start_in), .stop_in(stop_in),
        .low_in(low_in), .panel_toggle_in(panel_toggle_in), .panel_startstop_in(panel_startstop_in),
        .fault_in(fault_in), .motor_current_in(motor_current_in));
    initial forever #10 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        chk(k < 20, 1'b1);
        {psel, penable} <= 2'b00;
        if (k >= 20) begin
            test_done();
        end
    endtask
    // Poll a register until the masked value matches; compare it and stop only after 6000 reads without a match
    task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        n = 0;
        do begin
            apb(1'b0, a, 32'h0);
            n++;
        end while ((rd & m) !== e && n < 6000);
        if ((rd & m) !== e) begin
            chk(rd & m, e);
            test_done();
        end
    endtask
    task automatic test_done;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, CTRL_OFS, 32'h0); chk(rd & 32'h3, 32'h1);
        apb(1'b0, SETPT_OFS, 32'h0); chk(rd & 32'h3FF, 32'h3E8);
        apb(1'b1, STATUS_OFS, 32'h0);
        apb(1'b0, STATUS_OFS, 32'h0); chk(rd & 32'h7, 32'h3);
        apb(1'b0, 8'h40, 32'h0); chk({err, rd}, {1'b1, 32'h0});
        apb(1'b0, CURRENT_OFS, 32'h0); chk(rd, 32'h1234);
        apb(1'b1, SETPT_OFS, 32'h64);
        apb(1'b0, SETPT_OFS, 32'h0); chk(rd & 32'h3FF, 32'hFA);
        u_pump_host_model.set(2, 1'b1);
        u_pump_host_model.press(0);
        n = 0;
        while (at_speed_out !== 1'b1 && n < 15000) begin
            @(posedge pclk);
            n++;
        end
        if (at_speed_out !== 1'b1) begin
            chk(at_speed_out, 1'b1);
            test_done();
        end
        apb(1'b0, SPEED_OFS, 32'h0); chk(rd & 32'h3FF, 32'hC8);
        poll(SPEED_OFS, 32'h3FF, 32'hFA);
        repeat (200) @(posedge pclk);
        apb(1'b0, SPEED_OFS, 32'h0); chk(rd & 32'h3FF, 32'hFA);
        chk(at_speed_out, 1'b1);
        u_pump_host_model.press(1);
        poll(STATUS_OFS, 32'h7, 32'h3); chk(rd & 32'h7, 32'h3);
        apb(1'b1, CMD_OFS, 32'h20);
        apb(1'b0, CTRL_OFS, 32'h0); chk(rd & 32'h3, 32'h2);
        apb(1'b1, CMD_OFS, 32'h04);
        apb(1'b1, CMD_OFS, 32'h01);
        apb(1'b0, STATUS_OFS, 32'h0); chk(rd & 32'h7, 32'h1);
        poll(SPEED_OFS, 32'h3FF, 32'hFA); chk(rd & 32'h3FF, 32'hFA);
        apb(1'b1, CMD_OFS, 32'h08);
        apb(1'b0, STATUS_OFS, 32'h0); chk(rd & 32'h7, 32'h1);
        chk(at_speed_out, 1'b0);
        repeat (300) @(posedge pclk);
        apb(1'b1, CMD_OFS, 32'h04);
        apb(1'b0, STATUS_OFS, 32'h0); chk(rd & 32'h7, 32'h2);
        poll(STATUS_OFS, 32'h7, 32'h0); chk(rd & 32'h7, 32'h0);
        apb(1'b1, SETPT_OFS, 32'h104);
        poll(SPEED_OFS, 32'h3FF, 32'h104); chk(rd & 32'h3FF, 32'h104);
        apb(1'b0, STATUS_OFS, 32'h0); chk(rd & 32'h7, 32'h0);
        apb(1'b1, CMD_OFS, 32'h02);
        apb(1'b0, STATUS_OFS, 32'h0); chk(rd & 32'h7, 32'h2);
        poll(STATUS_OFS, 32'h7, 32'h3); chk(rd & 32'h7, 32'h3);
        apb(1'b1, CMD_OFS, 32'h01);
        repeat (200) @(posedge pclk);
        chk(motor_drive_out, 1'b1);
        u_pump_host_model.set(5, 1'b1);
        repeat (10) @(posedge pclk);
        apb(1'b0, STATUS_OFS, 32'h0); chk(rd & 32'h7, 32'h5);
        chk(motor_drive_out, 1'b0);
        poll(STATUS_OFS, 32'h7, 32'h4); chk(rd & 32'h7, 32'h4);
        u_pump_host_model.set(5, 1'b0);
        repeat (5) @(posedge pclk);
        apb(1'b1, CMD_OFS, 32'h10);
        apb(1'b0, STATUS_OFS, 32'h0); chk(rd & 32'h7, 32'h3);
        apb(1'b1, CMD_OFS, 32'h40);
        apb(1'b0, CTRL_OFS, 32'h0); chk(rd & 32'h3, 32'h1);
        u_pump_host_model.press(3);
        repeat (5) @(posedge pclk);
        apb(1'b0, CTRL_OFS, 32'h0); chk(rd & 32'h3, 32'h0);
        u_pump_host_model.press(4);
        poll(SPEED_OFS, 32'h3FF, 32'h10E); chk(rd & 32'h3FF, 32'h10E);
        u_pump_host_model.press(4);
        poll(STATUS_OFS, 32'h7, 32'h3); chk(rd & 32'h7, 32'h3);
        test_done();
    end
endmodule
